/* include/hem_pkg.sv */
// package: register map, bit layout and carrier types of the event manager
package hem_pkg;

    // register indices; the byte address on the bus is four times the index
    localparam logic [15:0] IDX_TOP_PEND   = 16'h4600;
    localparam logic [15:0] IDX_SUB_PEND0  = 16'h4602;
    localparam logic [15:0] IDX_SUB_MASK0  = 16'h460a;
    localparam logic [15:0] IDX_MISS       = 16'h4614;
    localparam logic [15:0] IDX_SWCTRL     = 16'h4616;
    localparam logic [15:0] IDX_GATE       = 16'h4618;
    localparam logic [15:0] IDX_MASK       = 16'h461a;

    localparam logic [31:0] ADDR_TOP_PEND  = {14'h0000, IDX_TOP_PEND, 2'b00};
    localparam logic [31:0] ADDR_SUB_PEND0 = {14'h0000, IDX_SUB_PEND0, 2'b00};
    localparam logic [31:0] ADDR_SUB_MASK0 = {14'h0000, IDX_SUB_MASK0, 2'b00};
    localparam logic [31:0] ADDR_MISS      = {14'h0000, IDX_MISS, 2'b00};
    localparam logic [31:0] ADDR_SWCTRL    = {14'h0000, IDX_SWCTRL, 2'b00};
    localparam logic [31:0] ADDR_GATE      = {14'h0000, IDX_GATE, 2'b00};
    localparam logic [31:0] ADDR_MASK      = {14'h0000, IDX_MASK, 2'b00};
    localparam logic [31:0] SUB_STRIDE     = 32'h0000_0008;

    // top-level bit positions
    localparam int B_WDOG   = 15;
    localparam int B_FAULT  = 14;
    localparam int B_TMR    = 13;
    localparam int B_GPIO   = 12;
    localparam int B_ADC    = 11;
    localparam int B_MACRX  = 10;
    localparam int B_MACTX  = 9;
    localparam int B_MACTMR = 8;
    localparam int B_SEC    = 7;
    localparam int B_SC2    = 6;
    localparam int B_SC1    = 5;
    localparam int B_SLEEP  = 4;
    localparam int B_BB     = 3;
    localparam int B_SIF    = 2;
    localparam int B_SW     = 1;
    localparam int B_GATE   = 0;

    // second-level modules, in register order
    localparam int NSUB     = 4;
    localparam int SUB_W    = 8;
    localparam int M_TMR    = 0;
    localparam int M_GPIO   = 1;
    localparam int M_SC1    = 2;
    localparam int M_SC2    = 3;
    localparam int SUB_BIT [NSUB] = '{B_TMR, B_GPIO, B_SC1, B_SC2};

    // bit masks
    localparam logic [15:0] TOP_BITS   = 16'hfffe;
    localparam logic [15:0] APP_BITS   = 16'h3860;
    localparam logic [15:0] SUB_TOPS   = 16'h3060;
    localparam logic [15:0] RST_16     = 16'h0000;
    localparam logic [SUB_W-1:0] RST_SUB = 8'h00;

    // single-cycle pulses from the system-side and converter sources
    typedef struct packed {
        logic wdog;
        logic fault;
        logic adc;
        logic macrx;
        logic mactx;
        logic mactmr;
        logic sec;
        logic sleep;
        logic bb;
        logic sif;
    } hem_sys_ev_t;

    // second-level sources: one byte per module, gpio byte is a level
    typedef logic [NSUB-1:0][SUB_W-1:0] hem_sub_ev_t;

endpackage

/* design/hem_event_manager.sv */
// event manager: two-level pending/mask hierarchy, missed-event record, irq and wake outputs
//
// Overview of operation
// - non-gpio sources are one-cycle pulses that set their pending bit on that edge
// - gpio sources are levels: pending is set for as long as the level holds
// - all enabled pending sources merge into one interrupt request line
// - top level holds one pending and one mask bit per major module
// - timer, gpio, serial one and two have sub-bits; others report only at top
// - a top-level event reaches the core only when its top mask bit is set
// - a sub-event feeds its module's top bit only when its sub mask bit is set
// - writing one to a direct or second-level pending bit clears it; writing zero does nothing
// - module top pending bit is the or of its enabled sub pending bits
// - an event in the same cycle as its clear leaves the bit set
// - a repeat of an enabled still-pending event is dropped and sets its missed bit
// - missed bits are cleared by writing one to them
// - events arriving while irqs are gated stay pending and fire when re-enabled
// - in application mode top pending, mask and missed writes to system bits are ignored
// - top mask layout from watchdog at 15 down to software at 1; bit 0 is zero
// - application mode may write only timer, gpio, converter and both serial bits
// - second-level pending and mask registers are fully writable in either mode
// - a write to the software trigger register raises the software event
// - global gate bit 0 gates the interrupt request, not wake; other bits read zero
// - the manager drives both the core's interrupt request and its wake-up input
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module hem_event_manager
    import hem_pkg::*;
(
    // clock, reset and freeze
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    // apb slave
    input  wire logic [31:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // event sources
    input  wire hem_sys_ev_t sys_ev,
    input  wire hem_sub_ev_t sub_ev,
    input  wire logic        app_mode,
    // to the processor core
    output logic             irq,
    output logic             wake
);

    // register state
    logic [15:0]                 top_pend_q;
    logic [15:0]                 top_mask_q;
    logic [15:0]                 miss_q;
    logic                        gate_q;
    logic [NSUB-1:0][SUB_W-1:0]  sub_pend_q;
    logic [NSUB-1:0][SUB_W-1:0]  sub_mask_q;
    logic [31:0]                 prdata_q;
    logic                        pready_q;
    logic                        pslverr_q;
    logic                        irq_q;
    logic                        wake_q;

    // gpio level synchroniser
    logic [SUB_W-1:0]            gpio_s1_q;
    logic [SUB_W-1:0]            gpio_s2_q;
    logic [SUB_W-1:0]            gpio_s3_q;
    logic [SUB_W-1:0]            gpio_lvl_q;
    logic [SUB_W-1:0]            gpio_prev_q;

    // decode
    logic                        hit_top;
    logic                        hit_miss;
    logic                        hit_sw;
    logic                        hit_gate;
    logic                        hit_mask;
    logic [NSUB-1:0]             hit_sp;
    logic [NSUB-1:0]             hit_sm;
    logic                        hit_any;
    logic                        wr_acc;
    logic [15:0]                 wr_allow;
    logic [15:0]                 wr_ones;
    logic [15:0]                 direct_ev;
    logic [15:0]                 sub_miss;
    logic [NSUB-1:0][SUB_W-1:0]  sub_src;
    logic [NSUB-1:0][SUB_W-1:0]  sub_rep;
    logic [31:0]                 rdata_d;
    logic                        req_d;

    assign hit_top  = (paddr == ADDR_TOP_PEND);
    assign hit_miss = (paddr == ADDR_MISS);
    assign hit_sw   = (paddr == ADDR_SWCTRL);
    assign hit_gate = (paddr == ADDR_GATE);
    assign hit_mask = (paddr == ADDR_MASK);
    assign hit_any  = hit_top | hit_miss | hit_sw | hit_gate | hit_mask | (|hit_sp) | (|hit_sm);

    // a write lands only on the access edge that the slave completes
    assign wr_acc   = ce & psel & penable & pwrite & pready_q;
    assign wr_allow = app_mode ? APP_BITS : TOP_BITS;
    assign wr_ones  = pwdata[15:0] & wr_allow;

    // direct top-level pulses; software trigger write acts as the software event
    always_comb begin
        direct_ev           = RST_16;
        direct_ev[B_WDOG]   = sys_ev.wdog;
        direct_ev[B_FAULT]  = sys_ev.fault;
        direct_ev[B_ADC]    = sys_ev.adc;
        direct_ev[B_MACRX]  = sys_ev.macrx;
        direct_ev[B_MACTX]  = sys_ev.mactx;
        direct_ev[B_MACTMR] = sys_ev.mactmr;
        direct_ev[B_SEC]    = sys_ev.sec;
        direct_ev[B_SLEEP]  = sys_ev.sleep;
        direct_ev[B_BB]     = sys_ev.bb;
        direct_ev[B_SIF]    = sys_ev.sif;
        direct_ev[B_SW]     = wr_acc & hit_sw;
    end

    // gpio pins come from another domain: three stages, accept when last two agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gpio_s1_q   <= RST_SUB;
            gpio_s2_q   <= RST_SUB;
            gpio_s3_q   <= RST_SUB;
            gpio_lvl_q  <= RST_SUB;
            gpio_prev_q <= RST_SUB;
        end else if (ce) begin
            gpio_s1_q   <= sub_ev[M_GPIO];
            gpio_s2_q   <= gpio_s1_q;
            gpio_s3_q   <= gpio_s2_q;
            gpio_lvl_q  <= (gpio_s2_q & gpio_s3_q) | (gpio_lvl_q & (gpio_s2_q | gpio_s3_q));
            gpio_prev_q <= gpio_lvl_q;
        end
    end

    // second level: one generate pass per module with sub-functions
    genvar m;
    generate
        for (m = 0; m < NSUB; m++) begin : g_sub
            assign hit_sp[m] = (paddr == ADDR_SUB_PEND0 + SUB_STRIDE * m);
            assign hit_sm[m] = (paddr == ADDR_SUB_MASK0 + SUB_STRIDE * m);

            // gpio sets while high, but only a fresh rise counts as a repeat
            if (m == M_GPIO) begin : g_lvl
                assign sub_src[m] = gpio_lvl_q;
                assign sub_rep[m] = gpio_lvl_q & ~gpio_prev_q;
            end else begin : g_pls
                assign sub_src[m] = sub_ev[m];
                assign sub_rep[m] = sub_ev[m];
            end

            // a repeat while pending and enabled is lost, only recorded
            assign sub_miss[SUB_BIT[m]] = |(sub_rep[m] & sub_pend_q[m] & sub_mask_q[m]);

            // sub pending: set beats the write-one clear, in either mode
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    sub_pend_q[m] <= RST_SUB;
                end else if (ce) begin
                    if (wr_acc && hit_sp[m]) begin
                        sub_pend_q[m] <= sub_src[m] | (sub_pend_q[m] & ~pwdata[SUB_W-1:0]);
                    end else begin
                        sub_pend_q[m] <= sub_src[m] | sub_pend_q[m];
                    end
                end
            end

            // sub mask: plain read/write
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    sub_mask_q[m] <= RST_SUB;
                end else if (ce && wr_acc && hit_sm[m]) begin
                    sub_mask_q[m] <= pwdata[SUB_W-1:0];
                end
            end
        end
    endgenerate

    // top pending: direct bits latch pulses, module bits mirror their enabled sub bits
    genvar b;
    generate
        for (b = 1; b < 16; b++) begin : g_top
            if (SUB_TOPS[b]) begin : g_mod
                int k;
                always_comb begin
                    k = 0;
                    for (int i = 0; i < NSUB; i++) begin
                        if (SUB_BIT[i] == b) begin
                            k = i;
                        end
                    end
                end
                always_ff @(posedge pclk or negedge presetn) begin
                    if (!presetn) begin
                        top_pend_q[b] <= 1'b0;
                    end else if (ce) begin
                        top_pend_q[b] <= |(sub_pend_q[k] & sub_mask_q[k]);
                    end
                end
            end else begin : g_dir
                assign sub_miss[b] = 1'b0;
                always_ff @(posedge pclk or negedge presetn) begin
                    if (!presetn) begin
                        top_pend_q[b] <= 1'b0;
                    end else if (ce) begin
                        top_pend_q[b] <= direct_ev[b] |
                            (top_pend_q[b] & ~(wr_acc & hit_top & wr_ones[b]));
                    end
                end
            end
        end
    endgenerate
    assign top_pend_q[B_GATE] = 1'b0;
    assign sub_miss[B_GATE]   = 1'b0;

    // top mask; bit 0 never stores
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            top_mask_q <= RST_16;
        end else if (ce && wr_acc && hit_mask) begin
            top_mask_q <= (top_mask_q & ~wr_allow) | wr_ones;
        end
    end

    // missed record: direct repeats, plus module repeats from the second level
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            miss_q <= RST_16;
        end else if (ce) begin
            miss_q <= ((direct_ev & top_pend_q & top_mask_q) | sub_miss) |
                      (miss_q & ~({16{wr_acc & hit_miss}} & wr_ones));
        end
    end

    // global gate
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gate_q <= 1'b0;
        end else if (ce && wr_acc && hit_gate) begin
            gate_q <= pwdata[B_GATE];
        end
    end

    // level request; pending bits survive a closed gate, so reopening re-raises it
    assign req_d = |(top_pend_q & top_mask_q);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_q  <= 1'b0;
            wake_q <= 1'b0;
        end else if (ce) begin
            irq_q  <= gate_q & req_d;
            wake_q <= req_d;
        end
    end

    // read mux; unused upper bits read zero
    always_comb begin
        rdata_d = 32'h0000_0000;
        if (hit_top) begin
            rdata_d[15:0] = top_pend_q;
        end
        if (hit_mask) begin
            rdata_d[15:0] = top_mask_q;
        end
        if (hit_miss) begin
            rdata_d[15:0] = miss_q;
        end
        if (hit_gate) begin
            rdata_d[B_GATE] = gate_q;
        end
        for (int i = 0; i < NSUB; i++) begin
            if (hit_sp[i]) begin
                rdata_d[SUB_W-1:0] = sub_pend_q[i];
            end
            if (hit_sm[i]) begin
                rdata_d[SUB_W-1:0] = sub_mask_q[i];
            end
        end
    end

    // apb answer: ready one enabled edge after psel, so a frozen setup edge cannot deadlock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else if (ce) begin
            pready_q  <= psel & ~pready_q;
            pslverr_q <= psel & ~pready_q & ~hit_any;
            if (psel && !pready_q) begin
                prdata_q <= pwrite ? 32'h0000_0000 : rdata_d;
            end
        end
    end

    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;
    assign irq     = irq_q;
    assign wake    = wake_q;

    // checks
    chk_pulse_sets: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && sys_ev.adc) |=> top_pend_q[B_ADC])
        else $error("converter pulse did not set pending");

    chk_gpio_level: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && gpio_lvl_q[0]) |=> sub_pend_q[M_GPIO][0])
        else $error("gpio level did not hold pending");

    chk_ack_clear: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_acc && hit_top && pwdata[B_ADC] && !sys_ev.adc) |=> !top_pend_q[B_ADC])
        else $error("write one did not clear pending");

    chk_sub_or: assert property (@(posedge pclk) disable iff (!presetn)
        ce |=> top_pend_q[B_TMR] == $past(|(sub_pend_q[M_TMR] & sub_mask_q[M_TMR])))
        else $error("module bit differs from or of sub bits");

    chk_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_acc && hit_top && pwdata[B_ADC] && sys_ev.adc) |=> top_pend_q[B_ADC])
        else $error("clear beat a simultaneous event");

    chk_miss_rec: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && sys_ev.adc && top_pend_q[B_ADC] && top_mask_q[B_ADC]) |=> miss_q[B_ADC])
        else $error("repeat event not recorded as missed");

    chk_app_guard: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_acc && hit_mask && app_mode) |=> top_mask_q[B_WDOG] == $past(top_mask_q[B_WDOG]))
        else $error("application write changed a system mask bit");

    chk_bit0_zero: assert property (@(posedge pclk) disable iff (!presetn)
        top_mask_q[B_GATE] == 1'b0 && miss_q[B_GATE] == 1'b0)
        else $error("bit zero of mask or missed set");

    chk_sw_raise: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_acc && hit_sw) |=> top_pend_q[B_SW])
        else $error("trigger write did not raise software event");

    chk_gate_off: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && !gate_q) |=> !irq_q)
        else $error("irq raised with gate closed");

    chk_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && gate_q && req_d) |=> irq_q ##0 wake_q)
        else $error("irq or wake missing for masked pending bit");

endmodule // hem_event_manager

`default_nettype wire

/* tb/hem_core_model.sv */
// core-side model: watches the request and wake-up lines of the event manager
`timescale 1ns/1ps
`default_nettype none

module hem_core_model (
    // clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // lines from the event manager
    input  wire logic       irq,
    input  wire logic       wake,
    // interrupt entries taken by the core
    output logic      [7:0] entries
);
    logic irq_q;

    // one entry per rising request; a level held high is one entry, not many
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_q   <= 1'b0;
            entries <= 8'h00;
        end else begin
            irq_q <= irq;
            if (irq && !irq_q && wake) begin
                entries <= entries + 8'h01;
            end
        end
    end
endmodule // hem_core_model

`default_nettype wire

/* tb/hem_event_manager_tb_top.sv */
// testbench: register access and event scenarios for the event manager
`timescale 1ns/1ps
`default_nettype none

module hem_event_manager_tb_top
    import hem_pkg::*;
;
    logic        pclk     = 1'b0;
    logic        presetn  = 1'b0;
    logic        ce       = 1'b1;
    logic [31:0] paddr    = 32'h0;
    logic        psel     = 1'b0;
    logic        penable  = 1'b0;
    logic        pwrite   = 1'b0;
    logic [31:0] pwdata   = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    hem_sys_ev_t sys_ev   = '0;
    hem_sub_ev_t sub_ev   = '0;
    logic        app_mode = 1'b0;
    logic        irq;
    logic        wake;
    logic [7:0]  entries;
    logic [31:0] rdv;
    logic        erv;
    hem_sys_ev_t no_ev    = '0;
    hem_sys_ev_t adc_ev   = 10'h080;
    int          err_count = 0;
    int          n_tests   = 0;

    // 25 MHz clock
    always #20 pclk = ~pclk;

    hem_event_manager uut (
        .pclk     (pclk),
        .presetn  (presetn),
        .ce       (ce),
        .paddr    (paddr),
        .psel     (psel),
        .penable  (penable),
        .pwrite   (pwrite),
        .pwdata   (pwdata),
        .prdata   (prdata),
        .pready   (pready),
        .pslverr  (pslverr),
        .sys_ev   (sys_ev),
        .sub_ev   (sub_ev),
        .app_mode (app_mode),
        .irq      (irq),
        .wake     (wake)
    );

    hem_core_model core (
        .pclk    (pclk),
        .presetn (presetn),
        .irq     (irq),
        .wake    (wake),
        .entries (entries)
    );

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t %s: got %h want %h", $time, what, got, exp);
        end
    endtask

    // one apb transfer; ev is pulsed so that it lands on the access edge
    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                       input hem_sys_ev_t ev, output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        sys_ev  <= ev;
        do begin
            @(posedge pclk);
            sys_ev <= '0;
            n++;
        end while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        chk(n, 32'h1, "wait states");
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [31:0] a, input logic [15:0] d);
        apb(1'b1, a, {16'h0000, d}, no_ev, rdv, erv);
    endtask

    task automatic rd(input logic [31:0] a, input logic [31:0] exp, input string what);
        apb(1'b0, a, 32'h0, no_ev, rdv, erv);
        chk(rdv, exp, what);
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask

    task automatic fire(input hem_sys_ev_t ev);
        sys_ev <= ev;
        @(posedge pclk);
        sys_ev <= '0;
        @(posedge pclk);
    endtask

    function automatic logic [31:0] sp(input int m);
        return ADDR_SUB_PEND0 + SUB_STRIDE * 32'(m);
    endfunction

    function automatic logic [31:0] sm(input int m);
        return ADDR_SUB_MASK0 + SUB_STRIDE * 32'(m);
    endfunction

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // watchdog: the sequence needs well under a thousand cycles
    initial begin
        #(40 * 20000);
        err_count++;
        $display("[ERR] %0t watchdog expired", $time);
        end_of_test();
    end

    // main sequence
    initial begin
        tick(2);
        presetn <= 1'b1;
        tick(1);
        rd(ADDR_GATE, 32'h0, "gate reset");
        rd(ADDR_MASK, 32'h0, "mask reset");
        rd(ADDR_TOP_PEND, 32'h0, "pend reset");
        wr(ADDR_MASK, 16'hffff);
        rd(ADDR_MASK, 32'h0000fffe, "mask bit0");
        wr(ADDR_GATE, 16'hffff);
        rd(ADDR_GATE, 32'h1, "gate width");
        app_mode <= 1'b1;
        wr(ADDR_MASK, 16'h0000);
        rd(ADDR_MASK, {16'h0, TOP_BITS & ~APP_BITS}, "app mask");
        app_mode <= 1'b0;
        apb(1'b0, 32'h0000_0100, 32'h0, no_ev, rdv, erv);
        chk({31'h0, erv}, 32'h1, "unmapped");
        wr(ADDR_MASK, 16'h0800);
        $display("done: registers");
        // direct event, repeat, ack, miss
        fire(adc_ev);
        rd(ADDR_TOP_PEND, 32'h0800, "adc pend");
        chk({30'h0, irq, wake}, 32'h3, "irq on");
        fire(adc_ev);
        rd(ADDR_MISS, 32'h0800, "miss set");
        wr(ADDR_TOP_PEND, 16'h0000);
        rd(ADDR_TOP_PEND, 32'h0800, "zero write");
        wr(ADDR_MISS, 16'h0800);
        rd(ADDR_MISS, 32'h0, "miss clear");
        wr(ADDR_TOP_PEND, 16'h0800);
        tick(1);
        chk({30'h0, irq, wake}, 32'h0, "irq off");
        // an event on the clearing edge must win
        fire(adc_ev);
        apb(1'b1, ADDR_TOP_PEND, 32'h0800, adc_ev, rdv, erv);
        rd(ADDR_TOP_PEND, 32'h0800, "set wins");
        wr(ADDR_TOP_PEND, 16'h0800);
        wr(ADDR_MISS, 16'h0800);
        $display("done: direct events");
        // gated event waits for the gate
        wr(ADDR_GATE, 16'h0000);
        fire(adc_ev);
        tick(2);
        chk({30'h0, irq, wake}, 32'h1, "gated");
        wr(ADDR_GATE, 16'h0001);
        tick(1);
        chk({30'h0, irq, wake}, 32'h3, "re-enabled");
        tick(1);
        chk({24'h0, entries}, 32'h3, "core entries");
        wr(ADDR_MASK, 16'h0000);
        tick(1);
        chk({30'h0, irq, wake}, 32'h0, "masked");
        rd(ADDR_TOP_PEND, 32'h0800, "masked pend");
        wr(ADDR_TOP_PEND, 16'h0800);
        // a pulse while the clock enable is low is not seen
        ce <= 1'b0;
        fire(adc_ev);
        ce <= 1'b1;
        rd(ADDR_TOP_PEND, 32'h0, "frozen");
        $display("done: gating");
        // second level: latch, enable, or of enabled bits
        wr(ADDR_MASK, 16'h2000);
        sub_ev[M_TMR] <= 8'h05;
        tick(1);
        sub_ev[M_TMR] <= 8'h00;
        tick(2);
        rd(ADDR_TOP_PEND, 32'h0, "sub unmasked");
        rd(sp(M_TMR), 32'h05, "sub pend");
        wr(sm(M_TMR), 16'h0005);
        tick(1);
        rd(ADDR_TOP_PEND, 32'h2000, "sub or");
        wr(sp(M_TMR), 16'h0001);
        tick(1);
        rd(ADDR_TOP_PEND, 32'h2000, "sub remain");
        wr(sp(M_TMR), 16'h0004);
        tick(1);
        rd(ADDR_TOP_PEND, 32'h0, "sub clear");
        // a repeated enabled sub event is recorded at the module's missed bit
        sub_ev[M_TMR] <= 8'h01;
        tick(1);
        sub_ev[M_TMR] <= 8'h00;
        tick(1);
        sub_ev[M_TMR] <= 8'h01;
        tick(1);
        sub_ev[M_TMR] <= 8'h00;
        tick(1);
        rd(ADDR_MISS, 32'h2000, "sub miss");
        wr(ADDR_MISS, 16'h2000);
        rd(ADDR_MISS, 32'h0, "sub miss clear");
        wr(sp(M_TMR), 16'h0001);
        $display("done: second level");
        // software event, application protection
        wr(ADDR_SWCTRL, 16'h0000);
        tick(1);
        rd(ADDR_TOP_PEND, 32'h0002, "soft event");
        app_mode <= 1'b1;
        wr(ADDR_TOP_PEND, 16'h0002);
        rd(ADDR_TOP_PEND, 32'h0002, "app ack");
        wr(sm(M_SC1), 16'h00a5);
        rd(sm(M_SC1), 32'h00a5, "app sub mask");
        app_mode <= 1'b0;
        wr(ADDR_TOP_PEND, 16'h0002);
        rd(ADDR_TOP_PEND, 32'h0, "sys ack");
        $display("done: software event");
        // gpio level keeps its pending bit set while high
        sub_ev[M_GPIO] <= 8'h01;
        tick(6);
        rd(sp(M_GPIO), 32'h01, "gpio level");
        wr(sp(M_GPIO), 16'h0001);
        tick(1);
        rd(sp(M_GPIO), 32'h01, "gpio held");
        sub_ev[M_GPIO] <= 8'h00;
        tick(6);
        wr(sp(M_GPIO), 16'h0001);
        rd(sp(M_GPIO), 32'h0, "gpio gone");
        $display("done: gpio level");
        end_of_test();
    end
endmodule // hem_event_manager_tb_top

`default_nettype wire
